//--- rtl/dcd_pkg.sv
package dcd_pkg;
  // Effective address fields, little-endian bit positions
  localparam int EA_W = 32;
  localparam int CLASS_HI = 12;
  localparam int CLASS_LO = 5;
  localparam int CLASS_W = CLASS_HI - CLASS_LO + 1;
  localparam int WORD_HI = 4;
  localparam int WORD_LO = 2;
  localparam int WORD_W = WORD_HI - WORD_LO + 1;
  // Result word fields, little-endian bit positions
  localparam int LINE_FIELD_A_HI = 31;
  localparam int LINE_FIELD_A_LO = 13;
  localparam int LINE_FIELD_A_W = LINE_FIELD_A_HI - LINE_FIELD_A_LO + 1;
  localparam int RSV0_HI = 12;
  localparam int RSV0_LO = 6;
  localparam int RES_DIRTY = 5;
  localparam int RES_VALID = 4;
  localparam int RSV1_HI = 3;
  localparam int RSV1_LO = 1;
  localparam int RES_LRU = 0;
  localparam int DATA_W = 32;
  // Register map
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam int CFG_WAY_BIT = 0;
  localparam int CFG_LINE_FIELD_A_BIT = 1;
  localparam int STS_BUSY_BIT = 0;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic WAY_A = 1'b0;
  localparam logic WAY_B = 1'b1;
  localparam logic LINE_FIELD_A_WORD = 1'b0;
  localparam logic LINE_FIELD_A_TAG = 1'b1;

  typedef enum logic [1:0] {
    DCD_IDLE = 2'b00,
    DCD_READ = 2'b01,
    DCD_CAPTURE = 2'b10
  } dcd_state_type;
endpackage : dcd_pkg

//--- rtl/dcd_pack.sv
module dcd_pack
  import dcd_pkg::*;
(
  input wire logic line_field_a_sel,
  input wire logic [LINE_FIELD_A_W-1:0] tag,
  input wire logic [DATA_W-1:0] data,
  input wire logic dirty,
  input wire logic valid,
  input wire logic lru,
  output logic [DATA_W-1:0] result
);
  always_comb begin
    result = '0;
    if (line_field_a_sel == LINE_FIELD_A_TAG) begin
      result[LINE_FIELD_A_HI:LINE_FIELD_A_LO] = tag;
    end else begin
      result[LINE_FIELD_A_HI:LINE_FIELD_A_LO] = data[LINE_FIELD_A_HI:LINE_FIELD_A_LO];
    end
    result[RES_DIRTY] = dirty;
    result[RES_VALID] = valid;
    result[RES_LRU] = lru;
  end
endmodule : dcd_pack

//--- rtl/dcd_debug_read.sv
// Contract
// - The congruence class is taken from effective-address bits 19 to 26 (big-endian).
// - The way is chosen by way_select_field, 0 for way A and 1 for way B.
// - The gathered line information is written to the destination register of the request.
// - Result bits 0 to 18 hold the tag when line_field_a_select_field is 1, else a data word.
// - The data word returned is chosen by effective-address bits 27 to 29.
// - Result bit 26 copies the dirty bit of the selected line.
// - Result bit 27 copies the valid bit of the selected line.
// - Result bit 31 copies the class replacement bit, 1 meaning way B least recently used.
//
// The implementer's own choices: the APB slave port and the register offsets.
module dcd_debug_read
  import dcd_pkg::*;
#(
  parameter int GPR_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [EA_W-1:0] req_ea,
  input wire logic [GPR_W-1:0] req_dest,
  output logic cache_rd_en,
  output logic [CLASS_W-1:0] cache_rd_class,
  output logic cache_rd_way,
  output logic [WORD_W-1:0] cache_rd_word,
  input wire logic [LINE_FIELD_A_W-1:0] cache_tag,
  input wire logic [DATA_W-1:0] cache_data,
  input wire logic cache_dirty,
  input wire logic cache_valid,
  input wire logic cache_lru,
  output logic gpr_we,
  output logic [GPR_W-1:0] gpr_addr,
  output logic [DATA_W-1:0] gpr_data
);
  if (GPR_W < 1 || GPR_W > 8) begin : gpr_w_check
    $error("GPR_W out of range");
  end

  dcd_state_type state;
  logic way_select_field;
  logic line_field_a_select_field;
  logic line_field_a_sel_q;
  logic [GPR_W-1:0] dest_q;
  logic [DATA_W-1:0] last_result;
  logic [DATA_W-1:0] next_result;
  logic take;
  logic apb_wr;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  assign take = req_valid && req_ready;
  assign req_ready = (state == DCD_IDLE);
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  // Core configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      way_select_field <= CFG_RESET[CFG_WAY_BIT];
      line_field_a_select_field <= CFG_RESET[CFG_LINE_FIELD_A_BIT];
    end else if (apb_wr && addr_is(paddr, OFS_CONFIG)) begin
      way_select_field <= pwdata[CFG_WAY_BIT];
      line_field_a_select_field <= pwdata[CFG_LINE_FIELD_A_BIT];
    end
  end

  // APB read data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (addr_is(paddr, OFS_CONFIG)) begin
        prdata[CFG_WAY_BIT] <= way_select_field;
        prdata[CFG_LINE_FIELD_A_BIT] <= line_field_a_select_field;
      end else if (addr_is(paddr, OFS_RESULT)) begin
        prdata <= last_result;
      end else if (addr_is(paddr, OFS_STATUS)) begin
        prdata[STS_BUSY_BIT] <= (state != DCD_IDLE);
      end
    end
  end

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(addr_is(paddr, OFS_CONFIG) || addr_is(paddr, OFS_RESULT)
                  || addr_is(paddr, OFS_STATUS));
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCD_IDLE;
    end else begin
      case (state)
        DCD_IDLE: begin
          if (take) begin
            state <= DCD_READ;
          end
        end
        DCD_READ: begin
          state <= DCD_CAPTURE;
        end
        DCD_CAPTURE: begin
          state <= DCD_IDLE;
        end
        default: begin
          state <= DCD_IDLE;
        end
      endcase
    end
  end

  // Read-only cache port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_rd_en <= 1'b0;
      cache_rd_class <= '0;
      cache_rd_way <= WAY_A;
      cache_rd_word <= '0;
      line_field_a_sel_q <= LINE_FIELD_A_WORD;
      dest_q <= '0;
    end else begin
      cache_rd_en <= take;
      if (take) begin
        cache_rd_class <= req_ea[CLASS_HI:CLASS_LO];
        cache_rd_way <= way_select_field;
        cache_rd_word <= req_ea[WORD_HI:WORD_LO];
        line_field_a_sel_q <= line_field_a_select_field;
        dest_q <= req_dest;
      end
    end
  end

  dcd_pack u_pack (
    .line_field_a_sel(line_field_a_sel_q),
    .tag(cache_tag),
    .data(cache_data),
    .dirty(cache_dirty),
    .valid(cache_valid),
    .lru(cache_lru),
    .result(next_result)
  );

  // Destination register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_we <= 1'b0;
      gpr_addr <= '0;
      gpr_data <= '0;
      last_result <= RESULT_RESET;
    end else begin
      gpr_we <= (state == DCD_CAPTURE);
      if (state == DCD_CAPTURE) begin
        gpr_addr <= dest_q;
        gpr_data <= next_result;
        last_result <= next_result;
      end
    end
  end

  // Checks
  class_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> cache_rd_en && cache_rd_class == $past(req_ea[CLASS_HI:CLASS_LO]))
    else $error("class index not taken from address");
  way_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> cache_rd_way == $past(way_select_field))
    else $error("way not taken from way select");
  gpr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |-> ##3 (gpr_we && gpr_addr == $past(req_dest, 3)))
    else $error("destination register not written");
  line_field_a_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |-> gpr_data[LINE_FIELD_A_HI:LINE_FIELD_A_LO] == ($past(line_field_a_select_field, 3) == LINE_FIELD_A_TAG
               ? $past(cache_tag) : $past(cache_data[LINE_FIELD_A_HI:LINE_FIELD_A_LO])))
    else $error("line_field_a field wrong");
  word_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> cache_rd_word == $past(req_ea[WORD_HI:WORD_LO]))
    else $error("word index not taken from address");
  dirty_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |-> gpr_data[RES_DIRTY] == $past(cache_dirty))
    else $error("dirty bit wrong");
  valid_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |-> gpr_data[RES_VALID] == $past(cache_valid))
    else $error("valid bit wrong");
  lru_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |-> gpr_data[RES_LRU] == $past(cache_lru))
    else $error("replacement bit wrong");
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |-> (gpr_data[RSV0_HI:RSV0_LO] == '0 && gpr_data[RSV1_HI:RSV1_LO] == '0))
    else $error("reserved bits not zero");
  config_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_wr && addr_is(paddr, OFS_CONFIG)) |=> $stable({way_select_field, line_field_a_select_field}))
    else $error("configuration changed without write");
  gpr_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpr_we |=> !gpr_we)
    else $error("destination write longer than one cycle");
  req_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> !req_ready ##1 !req_ready ##1 req_ready)
    else $error("request spacing wrong");
  read_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    cache_rd_en |=> !cache_rd_en)
    else $error("cache read strobe longer than one cycle");
  cfg_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && addr_is(paddr, OFS_CONFIG))
    |=> prdata[CFG_WAY_BIT] == $past(way_select_field)
    && prdata[CFG_LINE_FIELD_A_BIT] == $past(line_field_a_select_field))
    else $error("configuration readback wrong");
  busy_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && addr_is(paddr, OFS_STATUS))
    |=> prdata[STS_BUSY_BIT] == $past(!req_ready))
    else $error("busy status wrong");
endmodule : dcd_debug_read

//--- tb/dcd_cache_model.sv
package dcd_tb_pkg;
  // Line contents as {tag, data word, dirty, valid, lru}
  function automatic logic [53:0] dcd_line(logic [7:0] c, logic w, logic [2:0] wd);
    return {c, w, 10'h155, c, w, wd, 8'hC3, ~c, 4'hA, c[0] ^ w, c[1] | w, c[2]};
  endfunction : dcd_line
endpackage : dcd_tb_pkg

module dcd_cache_model
  import dcd_tb_pkg::*;
(
  input wire logic pclk,
  input wire logic rd_en,
  input wire logic [7:0] rd_class,
  input wire logic rd_way,
  input wire logic [2:0] rd_word,
  output logic [18:0] tag,
  output logic [31:0] data,
  output logic dirty,
  output logic valid,
  output logic lru
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle synchronous read; stale outputs flip every cycle after
  always @(posedge pclk) begin
    if (rd_en) begin
      {tag, data, dirty, valid, lru} <= dcd_line(rd_class, rd_way, rd_word);
    end else begin
      {tag, data, dirty, valid, lru} <= ~{tag, data, dirty, valid, lru};
    end
  end
endmodule : dcd_cache_model

//--- tb/dcd_debug_read_test.sv
module dcd_debug_read_test import dcd_tb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, req_ea = 0, prdata, cache_data, gpr_data, seen, exp;
  logic pready, pslverr, perr, req_ready, cache_rd_en, cache_rd_way, gpr_we;
  logic cache_dirty, cache_valid, cache_lru;
  logic [4:0] req_dest = 0, gpr_addr;
  logic [7:0] cache_rd_class;
  logic [2:0] cache_rd_word;
  logic [18:0] cache_tag;
  int bad_count = 0, n_tests = 0, i;
  // Rows: way, line_field_a, class, word, destination
  logic [17:0] rows [4] = '{{1'b0, 1'b0, 8'h00, 3'h0, 5'h00}, {1'b1, 1'b1, 8'hFF, 3'h7, 5'h1F},
    {1'b0, 1'b1, 8'hA5, 3'h3, 5'h05}, {1'b1, 1'b0, 8'h5A, 3'h5, 5'h11}};
  dcd_debug_read uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid, .req_ready, .req_ea, .req_dest, .cache_rd_en,
    .cache_rd_class, .cache_rd_way, .cache_rd_word, .cache_tag, .cache_data, .cache_dirty,
    .cache_valid, .cache_lru, .gpr_we, .gpr_addr, .gpr_data);
  dcd_cache_model cache (.pclk, .rd_en(cache_rd_en), .rd_class(cache_rd_class),
    .rd_way(cache_rd_way), .rd_word(cache_rd_word), .tag(cache_tag), .data(cache_data),
    .dirty(cache_dirty), .valid(cache_valid), .lru(cache_lru));
  function automatic logic [31:0] exp_res(logic [53:0] l, logic line_field_a);
    logic [31:0] r;
    r = 32'h0;
    r[31:13] = line_field_a ? l[53:35] : l[34:16];
    r[5] = l[2];
    r[4] = l[1];
    r[0] = l[0];
    return r;
  endfunction : exp_res
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task give_up;
    bad_count++;
    report_and_stop;
  endtask : give_up
  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      give_up;
    end
    seen = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task launch(logic [31:0] ea, logic [4:0] dst);
    int k;
    @(posedge pclk);
    req_valid <= 1'b1;
    req_ea <= ea;
    req_dest <= dst;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (req_ready !== 1'b1 && k < 20);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      give_up;
    end
  endtask : launch
  task req(logic [31:0] ea, logic [4:0] dst);
    int k;
    launch(ea, dst);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (gpr_we !== 1'b1 && k < 20);
    if (gpr_we !== 1'b1) begin
      give_up;
    end
  endtask : req
  initial forever #50 pclk = ~pclk;
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i++) begin
      apb(1, 12'h000, {30'h0, rows[i][16], rows[i][17]});
      req({19'h2A5A5, rows[i][15:8], rows[i][7:5], 2'h0}, rows[i][4:0]);
      exp = exp_res(dcd_line(rows[i][15:8], rows[i][17], rows[i][7:5]), rows[i][16]);
      chk("gpr_data", gpr_data, exp);
      chk("gpr_addr", {27'h0, gpr_addr}, {27'h0, rows[i][4:0]});
      apb(0, 12'h004, 32'h0);
      chk("result", seen, exp);
      apb(0, 12'h000, 32'h0);
      chk("config", seen, {30'h0, rows[i][16], rows[i][17]});
      $display("row %0d done", i);
    end
    apb(1, 12'hFFC, 32'h00000003);
    chk("unmapped error", {31'h0, perr}, 32'h1);
    apb(0, 12'h000, 32'h0);
    chk("config after unmapped", seen, 32'h1);
    apb(1, 12'h004, 32'hFFFFFFFF);
    chk("result write error", {31'h0, perr}, 32'h0);
    apb(0, 12'h004, 32'h0);
    chk("result kept", seen, exp);
    $display("refusal test done");
    launch({19'h2A5A5, 8'h3C, 3'h2, 2'h0}, 5'h07);
    apb(0, 12'h008, 32'h0);
    chk("status busy", seen, 32'h1);
    exp = exp_res(dcd_line(8'h3C, 1'b1, 3'h2), 1'b0);
    chk("gpr_data", gpr_data, exp);
    chk("gpr_addr", {27'h0, gpr_addr}, 32'h7);
    apb(0, 12'h008, 32'h0);
    chk("status idle", seen, 32'h0);
    apb(0, 12'h004, 32'h0);
    chk("result", seen, exp);
    $display("busy test done");
    launch({19'h2A5A5, 8'hC3, 3'h1, 2'h0}, 5'h0A);
    @(posedge pclk);
    presetn <= 0;
    @(negedge pclk);
    chk("reset outputs", {28'h0, gpr_we, req_ready, pready, cache_rd_en}, 32'h6);
    chk("reset gpr_data", gpr_data, 32'h0);
    chk("reset prdata", prdata, 32'h0);
    @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      chk("aborted write", {31'h0, gpr_we}, 32'h0);
    end
    apb(0, 12'h000, 32'h0);
    chk("config reset", seen, 32'h0);
    $display("reset test done");
    report_and_stop;
  end
endmodule : dcd_debug_read_test
